//--- pmcmd_pkg.sv
/*
  Constants, field layouts and carrier types for the power module management
  command block. Assumes the bus framing, checksum check and byte assembly of
  the management port are done outside and arrive as one decoded request.
*/
package pmcmd_pkg;

  // Command codes.
  localparam logic [7:0] CODE_CLEAR_ALL = 8'h03;
  localparam logic [7:0] CODE_CML       = 8'h7E;
  localparam logic [7:0] CODE_PROTO_REV = 8'h98;
  localparam logic [7:0] CODE_MTYPE     = 8'hD0;
  localparam logic [7:0] CODE_VOUT_GAIN = 8'hD1;
  localparam logic [7:0] CODE_VOUT_OFS  = 8'hD2;
  localparam logic [7:0] CODE_VIN_GAIN  = 8'hD3;
  localparam logic [7:0] CODE_VIN_OFS   = 8'hD4;
  localparam logic [7:0] CODE_IOUT_GAIN = 8'hD6;
  localparam logic [7:0] CODE_IOUT_OFS  = 8'hD7;
  localparam logic [7:0] CODE_FW_VER    = 8'hDB;
  localparam logic [7:0] CODE_ARA       = 8'hE0;
  localparam logic [7:0] CODE_PG_SENSE  = 8'hE2;
  localparam logic [7:0] CODE_DLS       = 8'hF0;

  // Transfer lengths in bytes.
  localparam logic [3:0] LEN_NONE  = 4'h0;
  localparam logic [3:0] LEN_BYTE  = 4'h1;
  localparam logic [3:0] LEN_WORD  = 4'h2;
  localparam logic [3:0] LEN_BLOCK = 4'hC;

  // Fault flag positions in comm_fault_flags.
  localparam int unsigned        BIT_BAD_CMD  = 7;
  localparam int unsigned        BIT_BAD_DATA = 6;
  localparam int unsigned        BIT_CHECKSUM = 5;
  localparam logic [7:0]         CML_MASK     = 8'hE0;

  // Protocol revision: part I in [7:5], bit 4 unused, part II in [3:0].
  localparam logic [2:0] REV_PART1 = 3'h2;
  localparam logic [3:0] REV_PART2 = 4'h2;

  // Module type field layout and reset values.
  localparam int unsigned BIT_WRITE_LOCK = 1;
  localparam int unsigned BIT_ISOLATED   = 7;
  localparam logic [4:0]  MTYPE_HI_RST   = 5'h00;
  localparam logic        WRITE_LOCK_RST = 1'b1;

  // Calibration limits and defaults.
  localparam logic [15:0] GAIN_MIN      = 16'h1999;
  localparam logic [15:0] GAIN_MAX      = 16'h2666;
  localparam logic [15:0] GAIN_UNITY    = 16'h2000;
  localparam logic [15:0] OFS_RST       = 16'h0000;
  localparam logic [4:0]  EXP_VOUT_OFS  = 5'h14;
  localparam logic [4:0]  EXP_VIN_OFS   = 5'h1D;
  localparam logic [4:0]  EXP_IOUT_OFS  = 5'h1C;

  // Other register fields.
  localparam int unsigned BIT_ARA_EN   = 4;
  localparam logic        ARA_RST      = 1'b0;
  localparam logic        PG_SENSE_RST = 1'b1;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [3:0]  len;
    logic        pec_bad;
    logic [95:0] data;
  } pmcmd_req_s;

  typedef struct packed {
    logic        valid;
    logic [3:0]  len;
    logic [95:0] data;
  } pmcmd_rsp_s;

  typedef struct packed {
    logic [15:0] vout_gain;
    logic [15:0] vout_ofs;
    logic [15:0] vin_gain;
    logic [15:0] vin_ofs;
    logic [15:0] iout_gain;
    logic [15:0] iout_ofs;
  } pmcmd_cal_s;

  localparam pmcmd_cal_s CAL_RST = '{GAIN_UNITY, OFS_RST, GAIN_UNITY, OFS_RST,
                                     GAIN_UNITY, OFS_RST};

endpackage

//--- pmcmd_regs.sv
/*
  Command register bank of the power module management port. Assumes each
  bus transaction arrives as one decoded request with its checksum already
  checked, and that a flash controller outside restores and keeps calibration.
*/
// Operation
// - Fault flags: bit 7 unknown command, 6 bad data, 5 checksum; each clearable.
// - Revision byte: part I in 7:5, part II in 3:0, bit 4 unused.
// - Module type is 16 bits; low byte designation 7:2, lock bit 1, bit 0 zero.
// - Designation top bit is 1 for isolated units, 0 for non-isolated.
// - High byte bits 2:0 read-only; other high bits and low byte bits 7:1 writable.
// - Lock bit blocks writes to calibration registers and the date block.
// - Voltage gain and offset trims persist in flash across power cycles.
// - Gain trims accept 0x1999 to 0x2666 only; voltage gains default 0x2000.
// - Offset trims need exponent -12, -3 and -4 for vout, vin and iout.
// - Firmware version is read-only, four decimal digits major.minor.patch.
// - Alert-response bit 4 clear: answer at strapped address during alert.
// - Bit 4 set: answer only the alert address; bits 7:5 read zero; resets zero.
// - Power-good sense bit 0 picks pin polarity, defaults 1; bits 7:1 read-only.
// - Date block moves as exactly twelve bytes in both directions.
module pmcmd_regs #(
  parameter logic [5:0]  MODULE_DESIG = 6'h20,  // Arbitrary value.
  parameter logic [15:0] FW_VERSION   = 16'h0100  // Arbitrary value.
) (
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  input  wire pmcmd_pkg::pmcmd_req_s req,
  output pmcmd_pkg::pmcmd_rsp_s    rsp,
  input  wire logic                nvm_load,
  input  wire pmcmd_pkg::pmcmd_cal_s nvm_image,
  output logic                     nvm_store,
  output pmcmd_pkg::pmcmd_cal_s    nvm_data,
  input  wire logic                alert_active,
  output logic                     ara_only,
  input  wire logic                power_ok_raw,
  output logic                     power_ok_pin
);
  import pmcmd_pkg::*;

  typedef struct packed {
    logic [7:0]  flags;
    logic [4:0]  mtype_hi;
    logic [5:0]  desig;
    logic        lock;
    pmcmd_cal_s  cal;
    logic        ara_en;
    logic        pg_sense;
    logic [95:0] dls;
    pmcmd_rsp_s  rsp;
    logic        store;
    logic        ara_only;
    logic        pg_pin;
  } pmcmd_state_s;

  pmcmd_state_s st_q;
  pmcmd_state_s st_d;

  function automatic logic gain_ok(input logic [15:0] v);
    return (v >= GAIN_MIN) && (v <= GAIN_MAX);
  endfunction

  logic        set_cmd;
  logic        set_data;
  logic        set_pec;
  logic [7:0]  clr;
  logic [15:0] wr;
  logic        locked;

  assign wr     = req.data[15:0];
  assign locked = st_q.lock;

  always_comb begin
    st_d          = st_q;
    st_d.rsp      = '0;
    st_d.store    = 1'b0;
    set_cmd       = 1'b0;
    set_data      = 1'b0;
    set_pec       = 1'b0;
    clr           = '0;
    if (nvm_load) begin
      st_d.cal = nvm_image;
    end
    if (req.valid) begin
      st_d.rsp.valid = 1'b1;
      if (req.pec_bad) begin
        set_pec = 1'b1;
      end else if (req.write) begin
        unique case (req.code)
          CODE_CLEAR_ALL: clr = CML_MASK;
          CODE_CML: begin
            if (req.len != LEN_BYTE) begin
              set_data = 1'b1;
            end else begin
              clr = wr[7:0] & CML_MASK;
            end
          end
          CODE_MTYPE: begin
            // A non-isolated designation is refused so the part cannot lie about itself.
            if (req.len != LEN_WORD || !wr[BIT_ISOLATED]) begin
              set_data = 1'b1;
            end else begin
              st_d.mtype_hi = wr[15:11];
              st_d.desig    = wr[7:2];
              st_d.lock     = wr[BIT_WRITE_LOCK];
            end
          end
          CODE_VOUT_GAIN, CODE_VIN_GAIN, CODE_IOUT_GAIN: begin
            if (req.len != LEN_WORD || locked || !gain_ok(wr)) begin
              set_data = 1'b1;
            end else begin
              st_d.store = 1'b1;
              if (req.code == CODE_VOUT_GAIN) begin
                st_d.cal.vout_gain = wr;
              end else if (req.code == CODE_VIN_GAIN) begin
                st_d.cal.vin_gain = wr;
              end else begin
                st_d.cal.iout_gain = wr;
              end
            end
          end
          CODE_VOUT_OFS: begin
            if (req.len != LEN_WORD || locked || wr[15:11] != EXP_VOUT_OFS) begin
              set_data = 1'b1;
            end else begin
              st_d.cal.vout_ofs = wr;
              st_d.store        = 1'b1;
            end
          end
          CODE_VIN_OFS: begin
            if (req.len != LEN_WORD || locked || wr[15:11] != EXP_VIN_OFS) begin
              set_data = 1'b1;
            end else begin
              st_d.cal.vin_ofs = wr;
              st_d.store       = 1'b1;
            end
          end
          CODE_IOUT_OFS: begin
            if (req.len != LEN_WORD || locked || wr[15:11] != EXP_IOUT_OFS) begin
              set_data = 1'b1;
            end else begin
              st_d.cal.iout_ofs = wr;
              st_d.store        = 1'b1;
            end
          end
          CODE_PROTO_REV, CODE_FW_VER: ;
          CODE_ARA: begin
            if (req.len != LEN_BYTE) begin
              set_data = 1'b1;
            end else begin
              st_d.ara_en = wr[BIT_ARA_EN];
            end
          end
          CODE_PG_SENSE: begin
            if (req.len != LEN_BYTE) begin
              set_data = 1'b1;
            end else begin
              st_d.pg_sense = wr[0];
            end
          end
          CODE_DLS: begin
            if (req.len != LEN_BLOCK || locked) begin
              set_data = 1'b1;
            end else begin
              st_d.dls = req.data;
            end
          end
          default: set_cmd = 1'b1;
        endcase
      end else begin
        unique case (req.code)
          CODE_CML: begin
            st_d.rsp.len  = LEN_BYTE;
            st_d.rsp.data = {88'h0, st_q.flags & CML_MASK};
          end
          CODE_PROTO_REV: begin
            st_d.rsp.len  = LEN_BYTE;
            st_d.rsp.data = {88'h0, REV_PART1, 1'b0, REV_PART2};
          end
          CODE_MTYPE: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, st_q.mtype_hi, 3'h0, st_q.desig, st_q.lock, 1'b0};
          end
          CODE_VOUT_GAIN: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, st_q.cal.vout_gain};
          end
          CODE_VOUT_OFS: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, st_q.cal.vout_ofs};
          end
          CODE_VIN_GAIN: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, st_q.cal.vin_gain};
          end
          CODE_VIN_OFS: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, st_q.cal.vin_ofs};
          end
          CODE_IOUT_GAIN: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, st_q.cal.iout_gain};
          end
          CODE_IOUT_OFS: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, st_q.cal.iout_ofs};
          end
          CODE_FW_VER: begin
            st_d.rsp.len  = LEN_WORD;
            st_d.rsp.data = {80'h0, FW_VERSION};
          end
          CODE_ARA: begin
            st_d.rsp.len  = LEN_BYTE;
            st_d.rsp.data = {88'h0, 3'h0, st_q.ara_en, 4'h0};
          end
          CODE_PG_SENSE: begin
            st_d.rsp.len  = LEN_BYTE;
            st_d.rsp.data = {88'h0, 7'h0, st_q.pg_sense};
          end
          CODE_DLS: begin
            st_d.rsp.len  = LEN_BLOCK;
            st_d.rsp.data = st_q.dls;
          end
          default: set_cmd = 1'b1;
        endcase
      end
    end
    // A new fault wins over a clear that lands in the same cycle.
    st_d.flags = (st_q.flags & ~clr) | ({set_cmd, set_data, set_pec, 5'h0});
    st_d.ara_only = st_q.ara_en & alert_active;
    st_d.pg_pin   = st_q.pg_sense ? power_ok_raw : ~power_ok_raw;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q          <= '0;
      st_q.mtype_hi <= MTYPE_HI_RST;
      st_q.desig    <= MODULE_DESIG | 6'h20;
      st_q.lock     <= WRITE_LOCK_RST;
      st_q.cal      <= CAL_RST;
      st_q.ara_en   <= ARA_RST;
      st_q.pg_sense <= PG_SENSE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign rsp          = st_q.rsp;
  assign nvm_store    = st_q.store;
  assign nvm_data     = st_q.cal;
  assign ara_only     = st_q.ara_only;
  assign power_ok_pin = st_q.pg_pin;

  sequence s_gain_wr_bad;
    req.valid && req.write && !req.pec_bad && req.code == CODE_VOUT_GAIN &&
    req.len == LEN_WORD && !gain_ok(wr);
  endsequence

  sequence s_locked_dls_wr;
    req.valid && req.write && !req.pec_bad && req.code == CODE_DLS && st_q.lock;
  endsequence

  AST_GAIN_RANGE: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_gain_wr_bad |=> st_q.flags[BIT_BAD_DATA] && st_q.cal.vout_gain == $past(st_q.cal.vout_gain))
    else $error("out of range gain accepted");

  AST_LOCKOUT: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_locked_dls_wr |=> st_q.dls == $past(st_q.dls) && st_q.flags[BIT_BAD_DATA])
    else $error("locked date block was written");

  AST_UNKNOWN_CMD: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.valid && !req.pec_bad && req.code == 8'h55 |=> st_q.flags[BIT_BAD_CMD])
    else $error("unknown command not flagged");

  AST_PEC_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.valid && req.pec_bad |=> st_q.flags[BIT_CHECKSUM] && rsp.valid && rsp.len == LEN_NONE)
    else $error("checksum failure not flagged");

  AST_FLAGS_LOW_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.valid && !req.write && !req.pec_bad && req.code == CODE_CML
    |=> rsp.data[4:0] == 5'h0 && rsp.data[95:8] == 88'h0)
    else $error("unsupported fault bit set");

  AST_REV_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.valid && !req.write && !req.pec_bad && req.code == CODE_PROTO_REV
    |=> rsp.valid && rsp.data[7:0] == 8'h42)
    else $error("protocol revision wrong");

  AST_OFS_EXP: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.valid && req.write && !req.pec_bad && req.code == CODE_VIN_OFS && wr[15:11] != 5'h1D
    |=> $stable(st_q.cal.vin_ofs) && st_q.flags[BIT_BAD_DATA] && !nvm_store)
    else $error("wrong exponent offset accepted");

  AST_DLS_LEN: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.valid && req.write && !req.pec_bad && req.code == CODE_DLS && req.len != 4'hC
    |=> $stable(st_q.dls))
    else $error("short date block accepted");

  AST_PG_POL: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st_q.pg_sense && $stable(st_q.pg_sense) |=> power_ok_pin == !$past(power_ok_raw))
    else $error("power good polarity wrong");

  AST_ARA: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st_q.ara_en |=> !ara_only)
    else $error("alert address used while disabled");

  AST_DESIG: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q.desig[5] == 1'b1)
    else $error("designation lost isolated mark");

endmodule

//--- pmcmd_host.sv
/*
  Host controller model that issues one decoded management request at a time.
  Assumes the block answers on the same edge that takes it; the answer is read at the next falling edge.
*/
module pmcmd_host (
  input  wire logic                  core_clk,
  output pmcmd_pkg::pmcmd_req_s      req,
  input  wire pmcmd_pkg::pmcmd_rsp_s rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmcmd_pkg::*;

  initial req = '0;

  // Released lines carry the inverse so a stale value is never mistaken for data.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [3:0] l,
                      input logic p, input logic [95:0] d, output logic ok,
                      output logic [3:0] ql, output logic [95:0] q);
    @(negedge core_clk);
    req = '{1'b1, w, c, l, p, d};
    @(posedge core_clk);
    @(negedge core_clk);
    ok = rsp.valid;
    ql = rsp.len;
    q = rsp.data;
    req = '{1'b0, ~w, ~c, ~l, ~p, ~d};
  endtask
endmodule

//--- testbench.sv
/*
  Self-checking bench for the management command register bank.
  Assumes the host model drives requests and flash images come from here.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pmcmd_pkg::*;

  logic        core_clk;
  logic        arst_n;
  logic        nvm_load;
  logic        alert_active;
  logic        power_ok_raw;
  logic        nvm_store;
  logic        ara_only;
  logic        power_ok_pin;
  pmcmd_req_s  req;
  pmcmd_rsp_s  rsp;
  pmcmd_cal_s  nvm_image;
  pmcmd_cal_s  nvm_data;
  int          failures;
  int          compares;
  int          cycles;
  logic [7:0]  tc [6] = '{CODE_VOUT_GAIN, CODE_VOUT_OFS, CODE_VIN_GAIN, CODE_VIN_OFS,
                          CODE_IOUT_GAIN, CODE_IOUT_OFS};
  logic [4:0]  oe [3] = '{EXP_VOUT_OFS, EXP_VIN_OFS, EXP_IOUT_OFS};
  logic [15:0] gv [4] = '{16'h1999, 16'h1998, 16'h2666, 16'h2667};
  logic [95:0] dv     = 96'h0C0B0A09_08070605_04030201;

  pmcmd_regs #(.MODULE_DESIG(6'h05), .FW_VERSION(16'h0318)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .req(req), .rsp(rsp),
    .nvm_load(nvm_load), .nvm_image(nvm_image), .nvm_store(nvm_store),
    .nvm_data(nvm_data), .alert_active(alert_active), .ara_only(ara_only),
    .power_ok_raw(power_ok_raw), .power_ok_pin(power_ok_pin)
  );

  pmcmd_host host (.core_clk(core_clk), .req(req), .rsp(rsp));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // The whole run needs well under a thousand cycles, so this only catches a hang.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic op(input logic w, input logic [7:0] c, input logic [3:0] l,
                    input logic [95:0] d, input logic [3:0] el, input logic [95:0] ed,
                    input logic p = 1'b0);
    logic        ok;
    logic [3:0]  ql;
    logic [95:0] q;
    logic [95:0] m;
    host.xfer(w, c, l, p, d, ok, ql, q);
    m = (96'h1 << (8 * el)) - 96'h1;
    chk($sformatf("valid_%h", c), 96'h1, {95'h0, ok});
    chk($sformatf("len_%h", c), {92'h0, el}, {92'h0, ql});
    chk($sformatf("data_%h", c), ed, q & m);
  endtask

  task automatic rd(input logic [7:0] c, input logic [3:0] l, input logic [95:0] e);
    op(1'b0, c, l, 96'h0, l, e);
  endtask

  task automatic wr(input logic [7:0] c, input logic [3:0] l, input logic [95:0] d);
    op(1'b1, c, l, d, LEN_NONE, 96'h0);
  endtask

  task automatic do_reset();
    @(negedge core_clk);
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
  endtask

  task automatic rst_chk();
    rd(CODE_CML, LEN_BYTE, 96'h0);
    rd(CODE_PROTO_REV, LEN_BYTE, 96'h42);
    rd(CODE_MTYPE, LEN_WORD, 96'h0096);
    rd(CODE_VOUT_GAIN, LEN_WORD, 96'h2000);
    rd(CODE_VIN_GAIN, LEN_WORD, 96'h2000);
    rd(CODE_VOUT_OFS, LEN_WORD, 96'h0);
    rd(CODE_FW_VER, LEN_WORD, 96'h0318);
    rd(CODE_ARA, LEN_BYTE, 96'h0);
    rd(CODE_PG_SENSE, LEN_BYTE, 96'h1);
    rd(CODE_DLS, LEN_BLOCK, 96'h0);
  endtask

  initial begin
    arst_n = 1'b0;
    nvm_load = 1'b0;
    nvm_image = CAL_RST;
    alert_active = 1'b0;
    power_ok_raw = 1'b1;
    do_reset();
    rst_chk();
    wr(CODE_VOUT_GAIN, LEN_WORD, 96'h2100);
    wr(CODE_DLS, LEN_BLOCK, dv);
    rd(CODE_VOUT_GAIN, LEN_WORD, 96'h2000);
    rd(CODE_DLS, LEN_BLOCK, 96'h0);
    rd(CODE_CML, LEN_BYTE, 96'h40);
    wr(CODE_CML, LEN_BYTE, 96'hE0);
    rd(CODE_CML, LEN_BYTE, 96'h0);
    wr(CODE_MTYPE, LEN_WORD, 96'hFFFC);
    rd(CODE_MTYPE, LEN_WORD, 96'hF8FC);
    wr(CODE_MTYPE, LEN_WORD, 96'h007E);
    rd(CODE_MTYPE, LEN_WORD, 96'hF8FC);
    rd(CODE_CML, LEN_BYTE, 96'h40);
    wr(CODE_CLEAR_ALL, LEN_NONE, 96'h0);
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 4; j++) begin
        wr(tc[2 * i], LEN_WORD, {80'h0, gv[j]});
        chk("nvm_store", {95'h0, j % 2 == 0}, {95'h0, nvm_store});
        chk("nvm_data", {80'h0, gv[j & 2]}, {80'h0, nvm_data[95 - 32 * i -: 16]});
        rd(tc[2 * i], LEN_WORD, {80'h0, gv[j & 2]});
      end
      wr(tc[2 * i + 1], LEN_WORD, {80'h0, oe[i] ^ 5'h01, 11'h2A5});
      wr(tc[2 * i + 1], LEN_WORD, {80'h0, oe[i], 11'h2A5});
      chk("nvm_store", 96'h1, {95'h0, nvm_store});
      rd(tc[2 * i + 1], LEN_WORD, {80'h0, oe[i], 11'h2A5});
      rd(CODE_CML, LEN_BYTE, 96'h40);
      wr(CODE_CLEAR_ALL, LEN_NONE, 96'h0);
    end
    op(1'b1, CODE_ARA, LEN_BYTE, 96'h10, LEN_NONE, 96'h0, 1'b1);
    op(1'b0, 8'h55, LEN_BYTE, 96'h0, LEN_NONE, 96'h0);
    wr(CODE_PROTO_REV, LEN_BYTE, 96'h0);
    wr(CODE_FW_VER, LEN_WORD, 96'h0);
    rd(CODE_CML, LEN_BYTE, 96'hA0);
    rd(CODE_ARA, LEN_BYTE, 96'h0);
    rd(CODE_PROTO_REV, LEN_BYTE, 96'h42);
    rd(CODE_FW_VER, LEN_WORD, 96'h0318);
    wr(CODE_CML, LEN_BYTE, 96'h20);
    rd(CODE_CML, LEN_BYTE, 96'h80);
    wr(CODE_CLEAR_ALL, LEN_NONE, 96'h0);
    alert_active = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("ara_only", 96'h0, {95'h0, ara_only});
    wr(CODE_ARA, LEN_BYTE, 96'hFF);
    rd(CODE_ARA, LEN_BYTE, 96'h10);
    chk("ara_only", 96'h1, {95'h0, ara_only});
    alert_active = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("ara_only", 96'h0, {95'h0, ara_only});
    chk("power_ok_pin", 96'h1, {95'h0, power_ok_pin});
    wr(CODE_PG_SENSE, LEN_BYTE, 96'hFE);
    rd(CODE_PG_SENSE, LEN_BYTE, 96'h0);
    chk("power_ok_pin", 96'h0, {95'h0, power_ok_pin});
    power_ok_raw = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("power_ok_pin", 96'h1, {95'h0, power_ok_pin});
    wr(CODE_DLS, LEN_BLOCK, dv);
    wr(CODE_DLS, 4'hB, ~dv);
    rd(CODE_DLS, LEN_BLOCK, dv);
    rd(CODE_CML, LEN_BYTE, 96'h40);
    nvm_image = '{16'h1A00, 16'hA001, 16'h2500, 16'hE802, 16'h2200, 16'hE003};
    nvm_load = 1'b1;
    @(negedge core_clk);
    nvm_load = 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(tc[i], LEN_WORD, {80'h0, nvm_image[95 - 16 * i -: 16]});
    end
    do_reset();
    rst_chk();
    end_sim();
  end
endmodule
